/* File: bench/srs_dev_model.sv */
/*
 Memory device model: decodes refresh and keeps the bank counter.
 Flags a refresh that lands inside a running refresh cycle, unless srExit is high in that cycle.
*/
`timescale 1ns/1ps
module srs_dev_model
    import srs_pkg::*;
(
    input logic mclk,
    input logic rst,
    input logic csN,
    input logic [3:0] ca,
    input logic srExit,
    output logic [2:0] devBank,
    output logic viol
);
    logic [7:0] refBusy; // Banks inside a refresh cycle
    int tmr; // Cycles left of the running cycle
    wire isRef = !csN && ca[2:0] == 3'h4;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            devBank <= 3'h0;
            refBusy <= 8'h00;
            tmr <= 0;
            viol <= 1'b0;
        end else if (srExit) begin
            devBank <= 3'h0;
        end else if (isRef) begin
            viol <= viol | (|refBusy);
            if (!ca[3]) begin
                refBusy <= 8'h01 << devBank;
                devBank <= devBank + 3'h1;
                tmr <= RFCPB_CYC - 1;
            end else begin
                // all banks busy, counter to zero
                refBusy <= 8'hFF;
                devBank <= 3'h0;
                tmr <= RFCAB_CYC - 1;
            end
        end else if (tmr > 1) begin
            tmr <= tmr - 1;
        end else begin
            tmr <= 0;
            refBusy <= 8'h00;
        end
    end
endmodule : srs_dev_model

/* File: bench/srs_host_monitor.sv */
/*
 Port checker for srs_refresh_host, bound to every instance.
 Assumes the srs_pkg codes and a two-edge issue latency.
*/
`timescale 1ns/1ps
module srs_host_monitor
    import srs_pkg::*;
#(
    parameter int NB = 8
) (
    input logic mclk,
    input logic rst,
    input logic [NB-1:0] bankIdle,
    input logic burstBusy,
    input logic selfRefExit,
    input logic csN_q,
    input logic [3:0] caCmd_q,
    input logic refIssued_q,
    input logic [2:0] nextBank_q,
    input logic [4:0] owed_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Recent exit samples; the synchroniser delays the clear a few edges
    logic [5:0] srSeen_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            srSeen_q <= 6'h00;
        end else begin
            srSeen_q <= {srSeen_q[4:0], selfRefExit};
        end
    end
    wire pbCmd = !csN_q && caCmd_q == CA_REF_PB;
    wire abCmd = !csN_q && caCmd_q == CA_REF_AB;
    a_cmd_legal: assert property (!csN_q |-> pbCmd || abCmd)
        else $error("refresh with bad code");
    a_idle_nop: assert property (csN_q |-> caCmd_q == CA_NOP)
        else $error("idle bus not NOP");
    a_pulse_pair: assert property (!csN_q |-> refIssued_q ##1 csN_q)
        else $error("select or flag width wrong");
    a_busy_hold: assert property (burstBusy |=> csN_q)
        else $error("refresh cut into a burst");
    a_pb_gap: assert property (pbCmd |=> csN_q [*2])
        else $error("per-bank spacing short");
    a_ab_gap: assert property (abCmd |=> csN_q [*5])
        else $error("all-bank spacing short");
    a_ab_clear: assert property (abCmd |=> nextBank_q == 3'h0)
        else $error("bank copy not cleared");
    a_pb_step: assert property (
        pbCmd |=> nextBank_q == $past(nextBank_q, 2) + 3'h1)
        else $error("bank copy did not step");
    a_bank_hold: assert property (
        $changed(nextBank_q) |-> !csN_q || !$past(csN_q) || |srSeen_q)
        else $error("bank copy moved alone");
    a_ab_idle: assert property (abCmd |-> &$past(bankIdle, 2))
        else $error("all-bank refresh with open bank");
    a_owed_cap: assert property (owed_q <= 5'h08)
        else $error("postponed count above eight");
    c_pb: cover property (pbCmd);
    c_ab: cover property (abCmd);
    c_busy: cover property (burstBusy ##1 burstBusy);
endmodule : srs_host_monitor
bind srs_refresh_host srs_host_monitor #(.NB(NB)) u_mon (
    .mclk(mclk), .rst(rst), .bankIdle(bankIdle), .burstBusy(burstBusy),
    .selfRefExit(selfRefExit), .csN_q(csN_q), .caCmd_q(caCmd_q),
    .refIssued_q(refIssued_q), .nextBank_q(nextBank_q), .owed_q(owed_q));

/* File: bench/tb_top.sv */
/*
 Self-checking bench for srs_refresh_host with a device model.
 Assumes the package timing; the interval is shortened to 64.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    import srs_pkg::*;
    localparam int RF = 64; // Shortened refresh interval
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bankIdle, actStrobe, preStrobe, h1, h2;
    logic burstBusy, selfRefExit, perBankMode, pullInReq;
    logic csN, refIssued, refUrgent, viol;
    logic [3:0] caCmd;
    logic [2:0] nextBank, devBank;
    logic [4:0] owed;
    int failures = 0, n_compared = 0, mBank = 0, nRef = 0, cyc = 0;
    int lastRef = 0;
    int q[$], qPb[$];
    always #12.5 mclk = ~mclk;
    srs_refresh_host #(.REFI(RF)) uut (.mclk(mclk), .rst(rst),
        .bankIdle(bankIdle), .actStrobe(actStrobe), .preStrobe(preStrobe),
        .burstBusy(burstBusy), .selfRefExit(selfRefExit),
        .perBankMode(perBankMode), .pullInReq(pullInReq), .csN_q(csN),
        .caCmd_q(caCmd), .refIssued_q(refIssued), .refUrgent_q(refUrgent),
        .nextBank_q(nextBank), .owed_q(owed));
    srs_dev_model dev (.mclk(mclk), .rst(rst), .csN(csN), .ca(caCmd),
        .srExit(selfRefExit), .devBank(devBank), .viol(viol));
    // Bank model, cadence and window counts at every refresh
    always @(posedge mclk) begin
        cyc++;
        h2 <= h1;
        h1 <= bankIdle;
        if (!rst && csN === 1'b0) begin
            `CHK(caCmd, perBankMode ? CA_REF_PB : CA_REF_AB)
            `CHK(perBankMode ? h2[mBank] : &h2, 1'b1)
            `CHK(cyc - lastRef <= 9 * RF, 1'b1)
            mBank = perBankMode ? (mBank + 1) % 8 : 0;
            lastRef = cyc;
            nRef++;
            // All-bank and per-bank commands have separate window budgets
            if (perBankMode) qPb.push_back(cyc);
            else q.push_back(cyc);
            while (q.size() > 0 && q[0] <= cyc - 2 * RF)
                void'(q.pop_front());
            while (qPb.size() > 0 && qPb[0] <= cyc - 2 * RF)
                void'(qPb.pop_front());
            `CHK(q.size() <= MAX_IN_2REFI, 1'b1)
            `CHK(qPb.size() <= 2 * 8 * 8, 1'b1)
        end
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
    endtask : ticks
    task automatic set_mode(input logic pb);
        burstBusy <= 1'b1;
        ticks(3);
        perBankMode <= pb;
        ticks(1);
        burstBusy <= 1'b0;
        ticks(1);
    endtask : set_mode
    // Quiesce the bus, then compare bank copies and the device
    task automatic end_test(input string name);
        burstBusy <= 1'b1;
        ticks(4);
        `CHK(nextBank, mBank[2:0])
        `CHK(devBank, mBank[2:0])
        `CHK(viol, 1'b0)
        burstBusy <= 1'b0;
        ticks(1);
        $display("test %s done", name);
    endtask : end_test
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(25));
        bankIdle = 8'hFF;
        actStrobe = 8'h00;
        preStrobe = 8'h00;
        burstBusy = 1'b0;
        selfRefExit = 1'b0;
        perBankMode = 1'b0;
        pullInReq = 1'b0;
        ticks(20);
        rst <= 1'b0;
        ticks(2);
        `CHK({csN, caCmd, nextBank, owed}, {1'b1, CA_NOP, 8'h00})
        ticks(3 * RF + 8);
        `CHK(nRef, 3)
        end_test("all_bank");
        set_mode(1'b1);
        // Random traffic on open banks while per-bank refresh runs
        repeat (2 * RF) begin
            @(posedge mclk);
            if ($urandom % 16 == 0) bankIdle <= 8'($urandom | $urandom);
            actStrobe <= ~bankIdle & 8'($urandom & $urandom);
            preStrobe <= ~bankIdle & 8'($urandom & $urandom);
            burstBusy <= ($urandom % 6 == 0);
        end
        bankIdle <= 8'hFF;
        actStrobe <= 8'h00;
        preStrobe <= 8'h00;
        end_test("per_bank");
        burstBusy <= 1'b1;
        selfRefExit <= 1'b1;
        ticks(1);
        selfRefExit <= 1'b0;
        mBank = 0;
        ticks(6);
        end_test("self_refresh_exit");
        set_mode(1'b0);
        ticks(RF + 8);
        end_test("all_after_per_bank");
        burstBusy <= 1'b1;
        ticks(7 * RF + RF / 2);
        `CHK(refUrgent, 1'b1)
        burstBusy <= 1'b0;
        ticks(2 * RF);
        `CHK(owed <= 5'h01, 1'b1)
        end_test("postpone");
        nRef = 0;
        pullInReq <= 1'b1;
        ticks(RF + RF / 2);
        `CHK(nRef >= 8 && nRef <= 11, 1'b1)
        pullInReq <= 1'b0;
        end_test("pull_in");
        final_report();
    end
    initial begin
        ticks(4000);
        failures++;
        final_report();
    end
endmodule : tb_top

/* File: src/srs_pkg.sv */
/*
 Shared constants for the refresh scheduler that drives a low-power
 DDR SDRAM command/address bus.
 Assumes a 40 MHz controller clock and a bench that models the memory.
*/
package srs_pkg;
    // Controller clock period in picoseconds
    localparam int CLK_PS = 25000;
    // Timing figures in nanoseconds
    localparam int T_RFCAB_NS = 130;
    localparam int T_RFCPB_NS = 60;
    localparam int T_RP_NS = 18;
    localparam int T_RRD_NS = 10;
    localparam int T_REFI_NS = 7800;
    // Least times round up to whole cycles, at least one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up
    localparam int RFCAB_CYC = cyc_up(T_RFCAB_NS);
    localparam int RFCPB_CYC = cyc_up(T_RFCPB_NS);
    localparam int RP_CYC = cyc_up(T_RP_NS);
    localparam int RRD_CYC = cyc_up(T_RRD_NS);
    // Interval is a longest time: round down
    localparam int REFI_CYC = (T_REFI_NS * 1000) / CLK_PS;
    // Postpone and pull-in budgets
    localparam int MAX_POSTPONE = 8;
    localparam int MAX_PULLIN = 8;
    localparam int MAX_IN_2REFI = 16;
    localparam int NUM_BANKS = 8;
    // Command/address encodings, bits 3..0
    localparam logic [3:0] CA_REF_PB = 4'h4;
    localparam logic [3:0] CA_REF_AB = 4'hC;
    localparam logic [3:0] CA_NOP = 4'h7;
    // Counter width for timers
    localparam int TW = 16;
endpackage : srs_pkg

/* File: src/srs_refresh_host.sv */
/*
 Refresh scheduler on the controller side of a low-power DDR SDRAM.
 Issues per-bank and all-bank refresh commands on the command bus,
 keeps its own copy of the device bank counter and the postpone /
 pull-in budget. Assumes the user side reports bank idle state,
 activates and precharges, and only asks for the bus between commands.
*/
`timescale 1ns/1ps
module srs_refresh_host
    import srs_pkg::*;
#(
    parameter int REFI = srs_pkg::REFI_CYC,
    parameter int NB = srs_pkg::NUM_BANKS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NB-1:0] bankIdle,
    input wire logic [NB-1:0] actStrobe,
    input wire logic [NB-1:0] preStrobe,
    input wire logic burstBusy,
    input wire logic selfRefExit,
    input wire logic perBankMode,
    input wire logic pullInReq,
    output logic csN_q,
    output logic [3:0] caCmd_q,
    output logic refIssued_q,
    output logic refUrgent_q,
    output logic [2:0] nextBank_q,
    output logic [4:0] owed_q
);
    import srs_pkg::*;

    // Eight banks only; the interval must fit the 16-bit counter and
    // leave room for a whole budget of refreshes
    if (NB != 8) begin : g_bad_nb
        $error("srs_refresh_host serves eight banks only");
    end
    if (REFI < 64 || REFI > 65535) begin : g_bad_refi
        $error("interval outside what the scheduler serves");
    end

    // Command slot states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_GAP = 3'b100
    } srs_state_e;

    srs_state_e state_q, state_d;
    logic csN_d;                 // Chip select toward the device
    logic [3:0] caCmd_d;         // Command bits 3..0
    logic refIssued_d;           // Pulse per refresh
    logic refUrgent_d;           // Postponed budget nearly spent
    logic [2:0] nextBank_d;      // Bank copy as it will stand
    logic [4:0] owed_d;          // Positive part of the debt
    logic [2:0] bank_q, bank_d;  // Copy of device bank counter
    logic isAb_q, isAb_d;        // Pending command kind
    logic [15:0] refiCnt_q, refiCnt_d;
    // Signed debt: positive owed, negative pulled in, in units of one
    logic signed [7:0] debt_q, debt_d;
    logic [5:0] pbSub_q, pbSub_d;  // Per-bank refreshes inside this unit
    // History of refresh counts over the last two intervals
    logic [7:0] win0_q, win0_d, win1_q, win1_d;
    logic [7:0] pbWin0_q, pbWin0_d, pbWin1_q, pbWin1_d;
    // Third bucket: a sliding window can straddle three intervals
    logic [7:0] win2_q, win2_d, pbWin2_q, pbWin2_d;
    logic [NB-1:0] preDone;
    logic abDone, pbDone, rrdDone;
    logic issuePb, issueAb;
    logic selfExitS1_q, selfExitS2_q;

    // Window test over three interval buckets. The partial current
    // bucket plus two whole earlier ones over-counts any sliding window
    // of two intervals, so the limit is never passed, at the cost of
    // an occasional refresh held back a little longer.
    function automatic logic win_ok(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic [7:0] c,
        input int limit
    );
        logic [9:0] s;
        s = 10'(a) + 10'(b) + 10'(c);
        return (int'(s) < limit);
    endfunction : win_ok

    // Separation timers: precharge per bank, and global ones
    genvar g;
    for (g = 0; g < NB; g++) begin : g_pre
        srs_timer #(.W(TW)) u_pre (
            .mclk(mclk), .rst(rst),
            .load(preStrobe[g]),
            .value(TW'(RP_CYC)),
            .done(preDone[g])
        );
    end
    srs_timer #(.W(TW)) u_ab (
        .mclk(mclk), .rst(rst), .load(issueAb),
        .value(TW'(RFCAB_CYC)), .done(abDone)
    );
    srs_timer #(.W(TW)) u_pb (
        .mclk(mclk), .rst(rst), .load(issuePb | issueAb),
        .value(TW'(RFCPB_CYC)), .done(pbDone)
    );
    srs_timer #(.W(TW)) u_rrd (
        .mclk(mclk), .rst(rst), .load(|actStrobe),
        .value(TW'(RRD_CYC)), .done(rrdDone)
    );

    // Self refresh exit comes from another domain: two flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            selfExitS1_q <= 1'b0;
            selfExitS2_q <= 1'b0;
        end else begin
            selfExitS1_q <= selfRefExit;
            selfExitS2_q <= selfExitS1_q;
        end
    end

    // Decide, schedule and drive the command slot
    always_comb begin
        logic wantRef, budgetOk, sepOk, pbWinOk;
        wantRef = 1'b0;
        budgetOk = 1'b0;
        sepOk = 1'b0;
        pbWinOk = 1'b0;
        state_d = state_q;
        csN_d = 1'b1;
        caCmd_d = CA_NOP;
        refIssued_d = 1'b0;
        bank_d = bank_q;
        isAb_d = isAb_q;
        refiCnt_d = refiCnt_q + 16'h0001;
        debt_d = debt_q;
        pbSub_d = pbSub_q;
        win0_d = win0_q;
        win1_d = win1_q;
        pbWin0_d = pbWin0_q;
        pbWin1_d = pbWin1_q;
        win2_d = win2_q;
        pbWin2_d = pbWin2_q;
        issuePb = 1'b0;
        issueAb = 1'b0;
        // Interval tick: one more refresh owed, window slides
        if (refiCnt_q == 16'(REFI - 1)) begin
            refiCnt_d = 16'h0000;
            debt_d = debt_q + 8'sh01;
            win2_d = win1_q;
            win1_d = win0_q;
            win0_d = 8'h00;
            pbWin2_d = pbWin1_q;
            pbWin1_d = pbWin0_q;
            pbWin0_d = 8'h00;
        end
        budgetOk = (debt_q > 8'sh00) ||
                   (pullInReq && (debt_q > -8'sh08));
        budgetOk = budgetOk &&
                   win_ok(win0_q, win1_q, win2_q, MAX_IN_2REFI);
        // per-bank window budget, twice eight times eight
        pbWinOk = win_ok(pbWin0_q, pbWin1_q, pbWin2_q, 2 * 8 * NB);
        wantRef = budgetOk && !burstBusy;
        case (state_q)
            ST_IDLE: begin
                if (wantRef) begin
                    if (perBankMode) begin
                        sepOk = bankIdle[bank_q] && preDone[bank_q] &&
                                abDone && pbDone && rrdDone && pbWinOk;
                        isAb_d = 1'b0;
                    end else begin
                        sepOk = (&bankIdle) && (&preDone) &&
                                abDone && pbDone;
                        isAb_d = 1'b1;
                    end
                    // A separation met here is not rechecked at the issue edge;
                    // a preStrobe or actStrobe reloading a timer in between goes unseen
                    if (sepOk) begin
                        state_d = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                // recheck burst in the issue cycle
                if (burstBusy) begin
                    state_d = ST_IDLE;
                end else begin
                    csN_d = 1'b0;
                    caCmd_d = isAb_q ? CA_REF_AB : CA_REF_PB;
                    refIssued_d = 1'b1;
                    state_d = ST_GAP;
                    if (isAb_q) begin
                        issueAb = 1'b1;
                        bank_d = 3'h0;
                        debt_d = debt_d - 8'sh01;
                        pbSub_d = 6'h00;
                        win0_d = win0_d + 8'h01;
                    end else begin
                        issuePb = 1'b1;
                        bank_d = bank_q + 3'h1;
                        pbWin0_d = pbWin0_d + 8'h01;
                        // Eight per-bank equal one all-bank unit
                        if (pbSub_q == 6'h07) begin
                            pbSub_d = 6'h00;
                            debt_d = debt_d - 8'sh01;
                            win0_d = win0_d + 8'h01;
                        end else begin
                            pbSub_d = pbSub_q + 6'h01;
                        end
                    end
                end
            end
            ST_GAP: begin
                // timers just loaded hold next refresh
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // self refresh exit resynchronises bank copy
        if (selfExitS2_q) begin
            bank_d = 3'h0;
            pbSub_d = 6'h00;
        end
        // warn the user side once seven units are owed, before an eighth
        refUrgent_d = (debt_d >= $signed(8'(MAX_POSTPONE - 1)));
        // Bank copy and positive debt shown as they will stand
        nextBank_d = bank_d;
        owed_d = (debt_d > 8'sh00) ? 5'(debt_d) : 5'h00;
    end

    // Register all scheduler state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            csN_q <= 1'b1;
            caCmd_q <= CA_NOP;
            refIssued_q <= 1'b0;
            bank_q <= 3'h0;
            isAb_q <= 1'b0;
            refiCnt_q <= 16'h0000;
            debt_q <= 8'sh00;
            pbSub_q <= 6'h00;
            win0_q <= 8'h00;
            win1_q <= 8'h00;
            pbWin0_q <= 8'h00;
            pbWin1_q <= 8'h00;
            win2_q <= 8'h00;
            pbWin2_q <= 8'h00;
            refUrgent_q <= 1'b0;
            nextBank_q <= 3'h0;
            owed_q <= 5'h00;
        end else begin
            state_q <= state_d;
            csN_q <= csN_d;
            caCmd_q <= caCmd_d;
            refIssued_q <= refIssued_d;
            bank_q <= bank_d;
            isAb_q <= isAb_d;
            refiCnt_q <= refiCnt_d;
            debt_q <= debt_d;
            pbSub_q <= pbSub_d;
            win0_q <= win0_d;
            win1_q <= win1_d;
            pbWin0_q <= pbWin0_d;
            pbWin1_q <= pbWin1_d;
            win2_q <= win2_d;
            pbWin2_q <= pbWin2_d;
            refUrgent_q <= refUrgent_d;
            nextBank_q <= nextBank_d;
            owed_q <= owed_d;
        end
    end
    // banks other than the target are left to the user side
    // write-AP spacing is kept by the user command path
endmodule : srs_refresh_host

/* File: src/srs_timer.sv */
/*
 Down-counting minimum-separation timer.
 Assumes load and count come from logic on the same clock.
*/
`timescale 1ns/1ps
module srs_timer #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_q, cnt_d;

    // Next count: reload wins over counting down
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    // Register only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Done once the window has run out
    assign done = (cnt_q == '0);
endmodule : srs_timer
